// ---- src/ckm_pkg.sv ----
package ckm_pkg;

  // system clock
  localparam int CLK_PERIOD_NS = 8;

  // crystal start-up: oscillations counted on the first oscillator pin
  localparam int          XTAL_COUNT     = 1024;
  localparam logic [9:0]  XTAL_LAST      = 10'(XTAL_COUNT - 1);

  // settle delay inserted on every clock origin change
  localparam int          SWITCH_DLY_NS  = 1000;
  localparam int          SWITCH_CYC_INT =
    (SWITCH_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  SWITCH_CYC     = 8'(SWITCH_CYC_INT);

  // warm-up of the fast internal oscillator before it reads stable
  localparam int          FAST_WARM_NS   = 2000;
  localparam int          FAST_WARM_INT  =
    (FAST_WARM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [8:0]  FAST_WARM_CYC  = 9'(FAST_WARM_INT);

  // internal oscillator models: system clocks per tick
  localparam int          FAST_DIV       = 16;
  localparam int          SLOW_DIV       = 4032;

  // frequency choice field
  localparam logic [2:0]  FREQ_RST       = 3'h6;
  localparam logic [2:0]  FREQ_SLOW      = 3'h0;
  localparam logic [6:0]  POST_FULL      = 7'h7F;

  // register map (byte addresses)
  localparam logic [7:0]  REG_CTRL       = 8'h00;
  localparam logic [7:0]  REG_STAT       = 8'h04;

  // control register fields
  localparam int          CTRL_SCS_BIT   = 0;
  localparam int          CTRL_STB_BIT   = 2;
  localparam int          CTRL_TO_BIT    = 3;
  localparam int          CTRL_FREQ_LSB  = 4;

  // status register fields
  localparam int          STAT_SW_BIT    = 0;
  localparam int          STAT_RUN_BIT   = 1;
  localparam int          STAT_HOLD_BIT  = 2;
  localparam int          STAT_MODE_LSB  = 4;

  // configured clock mode, fixed at power-up
  typedef enum logic [2:0] {
    MODE_LOW_GAIN  = 3'h0,
    MODE_MED_GAIN  = 3'h1,
    MODE_HIGH_GAIN = 3'h2,
    MODE_OUTSIDE   = 3'h3,
    MODE_RC_DIV    = 3'h4,
    MODE_RC_IO     = 3'h5,
    MODE_INT_IO    = 3'h6,
    MODE_INT_DIV   = 3'h7
  } ckm_mode_e;

  localparam ckm_mode_e MODE_RST = MODE_OUTSIDE;

  // start-up sequence, gray along wait -> count -> run
  typedef enum logic [1:0] {
    ST_WAIT  = 2'h0,
    ST_COUNT = 2'h1,
    ST_RUN   = 2'h3
  } ckm_st_e;

endpackage

// ---- src/ckm_tick_div.sv ----
`timescale 1ns/1ns
module ckm_tick_div #(
  parameter int DIV = 16
) (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic en_i,
  output logic      tick_o
);

  localparam int          W    = $clog2(DIV);
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] cnt_q;

  // stopped source restarts its period from zero
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= '0;
    end else if (!en_i) begin
      cnt_q <= '0;
    end else if (cnt_q == LAST) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= en_i && (cnt_q == LAST);
    end
  end

endmodule

// ---- src/ckm_top.sv ----
// Function
// - crystal modes count 1024 first-pin oscillations before clock is stable
// - count starts after reset and power-up timer, and on sleep wake-up
// - execution is held while the start-up count runs
// - every clock origin change inserts a settle delay before use
// - outside clock input mode skips the start-up count
// - outside clock mode: clock on first pin, output pin freed as I/O
// - fully static: no progress without source ticks, state kept
// - RC divided-out mode drives output pin with oscillator over four
// - RC pin I/O mode frees the output pin as general I/O
// - internal divided-out: clock-in pin I/O, clock-out carries freq/4
// - internal both-pins I/O mode frees both oscillator pins
// - software choice bit picks configured clock or internal oscillators
// - fast oscillator runs if freq field nonzero and choice or two-speed
// - software reads whether the fast oscillator is stable
// - fast oscillator postscaler yields seven derived frequencies
// - slow 31 kHz oscillator is selectable as the system clock
// - 111 is 8 MHz halving down to 001; 000 picks slow oscillator
// - any reset loads the frequency field with 110
// - timeout status reads 1 on configured clock, 0 on internal
//
// Our own choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ns
module ckm_top (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [2:0]  mode_cfg_i,
  input  wire logic        two_speed_startup_enable_i,
  input  wire logic        power_up_timer_en_i,
  input  wire logic        power_up_timer_done_i,
  input  wire logic        wake_i,
  input  wire logic        first_osc_pin_i,
  output logic             sys_ce_o,
  output logic             hold_o,
  output logic             fast_osc_run_o,
  output logic             output_osc_pin_o,
  output logic             output_osc_pin_oe_o,
  output logic             clock_in_pin_gpio_o,
  output logic             output_osc_pin_gpio_o
);

  ckm_pkg::ckm_mode_e mode_q;
  logic               mode_vld_q;
  ckm_pkg::ckm_st_e   st_q;
  ckm_pkg::ckm_st_e   st_d;
  logic [9:0]         xcnt_q;
  logic               first_osc_pin_q;
  logic               first_osc_pin_edge;
  logic               xtal_mode;
  logic               int_mode;
  logic               drive_out;
  logic [2:0]         freq_q;
  logic               scs_q;
  logic [3:0]         sel_d;
  logic [3:0]         cur_sel_q;
  logic [7:0]         sw_cnt_q;
  logic               fast_run;
  logic [8:0]         warm_q;
  logic               fast_stable_q;
  logic               fast_base;
  logic               slow_tick;
  logic [6:0]         post_q;
  logic [6:0]         post_mask;
  logic               int_tick;
  logic               src_tick;
  logic [1:0]         div_q;
  logic               wb_req;
  logic [31:0]        rd_d;

  assign xtal_mode = (mode_q == ckm_pkg::MODE_LOW_GAIN) ||
                     (mode_q == ckm_pkg::MODE_MED_GAIN) ||
                     (mode_q == ckm_pkg::MODE_HIGH_GAIN);
  assign int_mode  = (mode_q == ckm_pkg::MODE_INT_IO) ||
                     (mode_q == ckm_pkg::MODE_INT_DIV);
  assign drive_out = (mode_q == ckm_pkg::MODE_RC_DIV) ||
                     (mode_q == ckm_pkg::MODE_INT_DIV);

  // strap caught on the first edge after reset release, then frozen
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_q     <= ckm_pkg::MODE_RST;
      mode_vld_q <= 1'b0;
    end else if (!mode_vld_q) begin
      mode_q     <= ckm_pkg::ckm_mode_e'(mode_cfg_i);
      mode_vld_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      first_osc_pin_q <= 1'b0;
    end else begin
      first_osc_pin_q <= first_osc_pin_i;
    end
  end

  assign first_osc_pin_edge = first_osc_pin_i && !first_osc_pin_q;

  always_comb begin
    st_d = st_q;
    case (st_q)
      ckm_pkg::ST_WAIT: begin
        if (mode_vld_q && (!power_up_timer_en_i || power_up_timer_done_i)) begin
          st_d = xtal_mode ? ckm_pkg::ST_COUNT : ckm_pkg::ST_RUN;
        end
      end
      ckm_pkg::ST_COUNT: begin
        if (first_osc_pin_edge && (xcnt_q == ckm_pkg::XTAL_LAST)) begin
          st_d = ckm_pkg::ST_RUN;
        end
      end
      ckm_pkg::ST_RUN: begin
        if (wake_i && xtal_mode) begin
          st_d = ckm_pkg::ST_COUNT;
        end
      end
      default: st_d = ckm_pkg::ST_WAIT;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q   <= ckm_pkg::ST_WAIT;
      xcnt_q <= 10'h000;
      hold_o <= 1'b1;
    end else begin
      st_q   <= st_d;
      hold_o <= (st_d != ckm_pkg::ST_RUN);
      if (st_d != ckm_pkg::ST_COUNT || st_q != ckm_pkg::ST_COUNT) begin
        xcnt_q <= 10'h000;
      end else if (first_osc_pin_edge) begin
        xcnt_q <= xcnt_q + 10'h001;
      end
    end
  end

  // software choice bit and frequency field
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      freq_q <= ckm_pkg::FREQ_RST;
      scs_q  <= 1'b0;
    end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i &&
                 wb_sel_i[0] && wb_adr_i == ckm_pkg::REG_CTRL) begin
      freq_q <= wb_dat_i[ckm_pkg::CTRL_FREQ_LSB +: 3];
      scs_q  <= wb_dat_i[ckm_pkg::CTRL_SCS_BIT];
    end
  end

  // selection: {internal, frequency}; configured modes carry zero frequency
  always_comb begin
    sel_d = 4'h0;
    if (scs_q || int_mode) begin
      sel_d = {1'b1, freq_q};
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cur_sel_q <= 4'h0;
      sw_cnt_q  <= 8'h00;
    end else if (sw_cnt_q != 8'h00) begin
      sw_cnt_q <= sw_cnt_q - 8'h01;
      if (sw_cnt_q == 8'h01) begin
        cur_sel_q <= sel_d;
      end
    end else if (sel_d != cur_sel_q) begin
      sw_cnt_q <= ckm_pkg::SWITCH_CYC;
    end
  end

  // fast oscillator enable and warm-up
  assign fast_run = (freq_q != ckm_pkg::FREQ_SLOW) &&
                    (scs_q || two_speed_startup_enable_i || int_mode);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fast_osc_run_o <= 1'b0;
      warm_q         <= 9'h000;
      fast_stable_q  <= 1'b0;
    end else begin
      fast_osc_run_o <= fast_run;
      if (!fast_osc_run_o) begin
        warm_q        <= 9'h000;
        fast_stable_q <= 1'b0;
      end else if (warm_q == ckm_pkg::FAST_WARM_CYC) begin
        fast_stable_q <= 1'b1;
      end else begin
        warm_q <= warm_q + 9'h001;
      end
    end
  end

  ckm_tick_div #(.DIV(ckm_pkg::FAST_DIV)) u_fast (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .en_i   (fast_osc_run_o),
    .tick_o (fast_base)
  );

  ckm_tick_div #(.DIV(ckm_pkg::SLOW_DIV)) u_slow (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .en_i   (1'b1),
    .tick_o (slow_tick)
  );

  // postscaler: field 7 passes every tick, each step down halves
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      post_q <= 7'h00;
    end else if (fast_base && fast_stable_q) begin
      post_q <= post_q + 7'h01;
    end
  end

  assign post_mask = ckm_pkg::POST_FULL >> cur_sel_q[2:0];

  always_comb begin
    int_tick = fast_base && fast_stable_q &&
               ((post_q & post_mask) == post_mask);
    if (cur_sel_q[2:0] == ckm_pkg::FREQ_SLOW) begin
      int_tick = slow_tick;
    end
  end

  assign src_tick = cur_sel_q[3] ? int_tick : first_osc_pin_edge;

  // ticks come only from the live source; a stopped source freezes all
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sys_ce_o <= 1'b0;
    end else begin
      sys_ce_o <= src_tick && (sw_cnt_q == 8'h00) &&
                  (st_d == ckm_pkg::ST_RUN);
    end
  end

  // oscillator pin roles and divide-by-four clock out
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_q                 <= 2'h0;
      output_osc_pin_o      <= 1'b0;
      output_osc_pin_oe_o   <= 1'b0;
      clock_in_pin_gpio_o   <= 1'b0;
      output_osc_pin_gpio_o <= 1'b0;
    end else begin
      if (sys_ce_o) begin
        div_q <= div_q + 2'h1;
      end
      output_osc_pin_o      <= drive_out && div_q[1];
      output_osc_pin_oe_o   <= drive_out;
      clock_in_pin_gpio_o   <= int_mode;
      output_osc_pin_gpio_o <= (mode_q == ckm_pkg::MODE_OUTSIDE) ||
                               (mode_q == ckm_pkg::MODE_RC_IO) ||
                               (mode_q == ckm_pkg::MODE_INT_IO);
    end
  end

  // register read data
  always_comb begin
    rd_d = 32'h0000_0000;
    case (wb_adr_i)
      ckm_pkg::REG_CTRL: begin
        rd_d[ckm_pkg::CTRL_FREQ_LSB +: 3] = freq_q;
        rd_d[ckm_pkg::CTRL_TO_BIT]        = !cur_sel_q[3];
        rd_d[ckm_pkg::CTRL_STB_BIT]       = fast_stable_q;
        rd_d[ckm_pkg::CTRL_SCS_BIT]       = scs_q;
      end
      ckm_pkg::REG_STAT: begin
        rd_d[ckm_pkg::STAT_SW_BIT]        = (sw_cnt_q != 8'h00);
        rd_d[ckm_pkg::STAT_RUN_BIT]       = fast_osc_run_o;
        rd_d[ckm_pkg::STAT_HOLD_BIT]      = hold_o;
        rd_d[ckm_pkg::STAT_MODE_LSB +: 3] = mode_q;
      end
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_d : 32'h0000_0000;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_switch_req;
    (sw_cnt_q == 8'h00) && (sel_d != cur_sel_q);
  endsequence

  sequence s_quiet;
    !sys_ce_o [*8];
  endsequence

  a_xtal_last_edge: assert property (
    (st_q == ckm_pkg::ST_COUNT) && first_osc_pin_edge &&
    (xcnt_q == ckm_pkg::XTAL_LAST) |=> (st_q == ckm_pkg::ST_RUN) && !hold_o)
    else $error("start-up count did not end at 1024 edges");

  a_xtal_no_early: assert property (
    (st_q == ckm_pkg::ST_COUNT) &&
    !(first_osc_pin_edge && (xcnt_q == ckm_pkg::XTAL_LAST))
    |=> (st_q == ckm_pkg::ST_COUNT))
    else $error("start-up count left early");

  a_wake_restart: assert property (
    (st_q == ckm_pkg::ST_RUN) && wake_i && xtal_mode
    |=> (st_q == ckm_pkg::ST_COUNT) && (xcnt_q == 10'h000) && hold_o)
    else $error("wake-up did not restart start-up count");

  a_hold_count: assert property (
    (st_q == ckm_pkg::ST_COUNT) |-> hold_o && !sys_ce_o)
    else $error("execution not held during start-up count");

  a_switch_settle: assert property (
    s_switch_req |-> ##2 s_quiet)
    else $error("clock ticks passed during switch delay");

  a_outside_nocnt: assert property (
    (mode_q == ckm_pkg::MODE_OUTSIDE) |-> (st_q != ckm_pkg::ST_COUNT))
    else $error("outside clock mode entered start-up count");

  a_outside_pins: assert property (
    mode_vld_q && (mode_q == ckm_pkg::MODE_OUTSIDE)
    |=> output_osc_pin_gpio_o && !output_osc_pin_oe_o)
    else $error("output pin not released in outside clock mode");

  a_divided_clock_out_pin_tick: assert property (
    $rose(output_osc_pin_o) |-> $past(sys_ce_o, 2) && output_osc_pin_oe_o)
    else $error("clock out moved without a system tick");

  a_fast_enable: assert property (
    (freq_q != ckm_pkg::FREQ_SLOW) && scs_q |=> fast_osc_run_o)
    else $error("fast oscillator not enabled");

  a_fast_off: assert property (
    (freq_q == ckm_pkg::FREQ_SLOW) |=> !fast_osc_run_o ##1 !fast_stable_q)
    else $error("fast oscillator ran with slow frequency selected");

  a_mode_frozen: assert property (
    mode_vld_q |=> $stable(mode_q))
    else $error("configured mode changed after power-up");

endmodule

// ---- dv/ckm_osc_model.sv ----
`timescale 1ns/1ns
module ckm_osc_model (
  input  wire logic       clk_i,
  input  wire logic       run_i,
  input  wire logic [2:0] half_i,
  output logic            pin_o
);
  logic [2:0] cnt_q;

  // a stopped oscillator stands low, it never freezes high
  always_ff @(posedge clk_i) begin
    if (!run_i) begin
      pin_o <= 1'b0;
      cnt_q <= 3'h0;
    end else if (cnt_q >= half_i - 3'h1) begin
      pin_o <= ~pin_o;
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_q + 3'h1;
    end
  end
endmodule

// ---- dv/ckm_top_tb.sv ----
`timescale 1ns/1ns
module ckm_top_tb;
  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h00000000;
  logic [2:0]  mode = 3'h3;
  logic [2:0]  half = 3'h2;
  logic        tse = 1'b0;
  logic        pe = 1'b0;
  logic        pd = 1'b0;
  logic        wake = 1'b0;
  logic        orun = 1'b0;
  logic [31:0] rd;
  logic [31:0] rdat;
  logic [31:0] seed = 32'h00009108;
  logic [2:0]  f;
  logic        ack, pin, ce, hold, frun, opin, oe, cgp, ogp;
  int          mismatches = 0;
  int          comparisons = 0;
  int          cyc_n = 0;
  int          n_ce, n_pin, n_out;

  initial forever #4 clk_i = ~clk_i;

  ckm_top DUT (
    .clk_i(clk_i), .nrst_i(nrst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rd), .wb_ack_o(ack), .mode_cfg_i(mode),
    .two_speed_startup_enable_i(tse), .power_up_timer_en_i(pe),
    .power_up_timer_done_i(pd), .wake_i(wake), .first_osc_pin_i(pin),
    .sys_ce_o(ce), .hold_o(hold), .fast_osc_run_o(frun),
    .output_osc_pin_o(opin), .output_osc_pin_oe_o(oe),
    .clock_in_pin_gpio_o(cgp), .output_osc_pin_gpio_o(ogp)
  );

  ckm_osc_model osc (.clk_i(clk_i), .run_i(orun), .half_i(half),
                     .pin_o(pin));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // expected {oe, clock-in gpio, output gpio} per configured mode
  function automatic logic [2:0] pins(input logic [2:0] m);
    case (m)
      3'h3: return 3'h1;
      3'h4: return 3'h4;
      3'h5: return 3'h1;
      3'h6: return 3'h3;
      3'h7: return 3'h6;
      default: return 3'h0;
    endcase
  endfunction

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic near(input int got, input int exp, input int tol);
    chk(32'(got >= exp - tol && got <= exp + tol), 32'h1);
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rdat = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rst(input logic [2:0] m);
    nrst_i <= 1'b0;
    mode <= m;
    orun <= 1'b0;
    repeat (12) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic cnt(input int win);
    logic pp, po;
    n_ce = 0;
    n_pin = 0;
    n_out = 0;
    pp = pin;
    po = opin;
    repeat (win) begin
      @(posedge clk_i);
      n_ce += int'(ce === 1'b1);
      n_pin += int'(pin & !pp);
      n_out += int'(opin & !po);
      pp = pin;
      po = opin;
    end
  endtask

  // runs the oscillator through one full start-up count
  task automatic xtal();
    logic pp;
    int k;
    k = 0;
    pp = 1'b0;
    orun <= 1'b1;
    while (k < 1024) begin
      @(posedge clk_i);
      chk(32'({hold, ce}), 32'h2);
      k += int'(pin & !pp);
      pp = pin;
    end
    repeat (3) @(posedge clk_i);
    chk(32'(hold), 32'h0);
  endtask

  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 90000) begin
      mismatches++;
      end_of_test();
    end
  end

  initial begin
    for (int m = 0; m < 8; m++) begin
      rst(3'(m));
      chk(32'({oe, cgp, ogp}), 32'(pins(3'(m))));
      chk(32'(hold), 32'(m < 3));
      repeat (150) @(posedge clk_i);
      wb(1'b0, ckm_pkg::REG_CTRL, 32'h0);
      chk(rdat & 32'hFFFFFFFB, {24'h0, 1'b0, ckm_pkg::FREQ_RST,
          (m < 6), 3'h0});
      wb(1'b0, ckm_pkg::REG_STAT, 32'h0);
      chk(rdat & 32'h00000070, 32'(m) << 4);
    end
    for (int m = 0; m < 3; m++) begin
      pe <= 1'b1;
      pd <= 1'b0;
      half <= 3'(rnd() % 3 + 1);
      rst(3'(m));
      orun <= 1'b1;
      repeat (300) @(posedge clk_i);
      chk(32'(hold), 32'h1);
      orun <= 1'b0;
      pd <= 1'b1;
      repeat (4) @(posedge clk_i);
      xtal();
      orun <= 1'b0;
      wake <= 1'b1;
      @(posedge clk_i);
      wake <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk(32'(hold), 32'h1);
      xtal();
    end
    pe <= 1'b0;
    half <= 3'h2;
    rst(3'h3);
    orun <= 1'b1;
    cnt(400);
    near(n_ce, n_pin, 1);
    orun <= 1'b0;
    repeat (10) @(posedge clk_i);
    cnt(300);
    chk(32'(n_ce), 32'h0);
    rst(3'h4);
    orun <= 1'b1;
    cnt(1600);
    near(n_out, n_pin / 4, 1);
    orun <= 1'b0;
    rst(3'h7);
    repeat (300) @(posedge clk_i);
    cnt(2048);
    near(n_out, n_ce / 4, 1);
    rst(3'h3);
    tse <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(32'(frun), 32'h1);
    tse <= 1'b0;
    wb(1'b1, ckm_pkg::REG_CTRL, 32'h71);
    wb(1'b0, ckm_pkg::REG_STAT, 32'h0);
    chk(rdat & 32'h3, 32'h3);
    repeat (400) @(posedge clk_i);
    wb(1'b0, ckm_pkg::REG_CTRL, 32'h0);
    chk(rdat, 32'h75);
    cnt(1600);
    near(n_ce, 100, 2);
    repeat (2) begin
      f = 3'(rnd() % 7 + 1);
      wb(1'b1, ckm_pkg::REG_CTRL, {25'h0, f, 4'h1});
      repeat (200) @(posedge clk_i);
      cnt(4096);
      near(n_ce, 4096 / (16 << (7 - int'(f))), 2);
    end
    wb(1'b1, ckm_pkg::REG_CTRL, 32'h01);
    repeat (3) @(posedge clk_i);
    chk(32'(frun), 32'h0);
    repeat (200) @(posedge clk_i);
    cnt(8200);
    near(n_ce, 2, 1);
    wb(1'b1, 8'h08, 32'hFF);
    wb(1'b0, 8'h08, 32'h0);
    chk(rdat, 32'h0);
    wb(1'b1, ckm_pkg::REG_CTRL, 32'h60);
    repeat (200) @(posedge clk_i);
    wb(1'b0, ckm_pkg::REG_CTRL, 32'h0);
    chk(rdat & 32'hFFFFFFFB, 32'h68);
    end_of_test();
  end
endmodule
